// ---- spp_pkg.sv ----
//------------------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------------------
// Notes on behaviour
// - A low pointer load on a clock edge copies the address pins into the pointer.
// - A high count enable on a clock edge leaves the pointer where it is.
// - The pointer does not advance on the cycle right after a pin load.
// - A low buffer start input loads the pointer with that buffer's start address.
// - After a buffer start load the pointer may advance on the very next cycle.
// - A select low with read/write high puts the word at the pointer on the data pins.
// - A select low with read/write low stores the input word, even straight after a read.
// - While read/write is low the data pins stay undriven until a high level is clocked in.
// - A repeated write with count enable high writes the same location again.
// - Consecutive writes with count enable low go to successive addresses.
// - Consecutive reads with count enable low return successive addresses.
// - Reset forces the read/write state to write, so the outputs stay off.
// - A stopped pointer resumes when software writes zero to bit 4 of command location 4.
package spp_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	localparam int REG_AW = 4;
	localparam int EVT_W  = 3;

	// Register offsets on the software port.
	localparam logic [REG_AW-1:0] OFS_STATUS = 4'h0;
	localparam logic [REG_AW-1:0] OFS_MASK   = 4'h1;
	localparam logic [REG_AW-1:0] OFS_START1 = 4'h2;
	localparam logic [REG_AW-1:0] OFS_START2 = 4'h3;
	localparam logic [REG_AW-1:0] OFS_CMD    = 4'h4;
	localparam logic [REG_AW-1:0] OFS_END    = 4'h5;
	localparam logic [REG_AW-1:0] OFS_RADDR  = 4'h6;
	localparam logic [REG_AW-1:0] OFS_RDATA  = 4'h7;
	localparam logic [REG_AW-1:0] OFS_PTR    = 4'h8;

	// Event bits of the status and mask registers.
	localparam int EVT_EOB     = 0;
	localparam int EVT_START   = 1;
	localparam int EVT_RESTART = 2;

	// Command register fields.
	localparam int CMD_STOP_EN = 0;
	localparam int CMD_HALT    = 4;

	// Reset values.
	localparam logic [ADDR_W-1:0] RST_START1 = 13'h0000;
	localparam logic [ADDR_W-1:0] RST_START2 = 13'h1000;
	localparam logic [ADDR_W-1:0] RST_END    = 13'h1FFF;
	localparam logic [EVT_W-1:0]  RST_MASK   = 3'h0;
endpackage : spp_pkg

// ---- spp_seq_port.sv ----
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/100ps
module spp_seq_port (
	// Clock and reset
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_i,
	// Sequential port controls
	input  wire logic                       pointer_load_n_i,
	input  wire logic                       count_enable_n_i,
	input  wire logic                       buffer_one_start_load_n_i,
	input  wire logic                       buffer_two_start_load_n_i,
	input  wire logic                       seq_select_n_i,
	input  wire logic                       seq_read_write_i,
	input  wire logic                       seq_output_enable_n_i,
	input  wire logic [spp_pkg::ADDR_W-1:0] seq_addr_i,
	// Sequential data pins
	input  wire logic [spp_pkg::DATA_W-1:0] seq_data_i,
	output logic      [spp_pkg::DATA_W-1:0] seq_data_o,
	output logic                            seq_data_oe_o,
	// Buffer flags
	output logic                            end_of_buffer_flag_o,
	output logic                            buffer_start_flag_o,
	// Software register port
	input  wire logic [spp_pkg::REG_AW-1:0] reg_addr_i,
	input  wire logic [spp_pkg::DATA_W-1:0] reg_wdata_i,
	input  wire logic                       reg_we_i,
	input  wire logic                       reg_re_i,
	output logic      [spp_pkg::DATA_W-1:0] reg_rdata_o,
	// Interrupt
	output logic                            irq_o
);

	//--------------------------------------------------------------------------
	// State
	//--------------------------------------------------------------------------
	typedef struct packed {
		logic [spp_pkg::ADDR_W-1:0] ptr;
		logic                       skip;
		logic                       rd_state;
		logic [spp_pkg::DATA_W-1:0] dout;
		logic                       doe;
		logic                       halted;
		logic                       stop_en;
		logic [spp_pkg::EVT_W-1:0]  status;
		logic [spp_pkg::EVT_W-1:0]  mask;
		logic [spp_pkg::ADDR_W-1:0] start1;
		logic [spp_pkg::ADDR_W-1:0] start2;
		logic [spp_pkg::ADDR_W-1:0] end_addr;
		logic [spp_pkg::ADDR_W-1:0] raddr;
		logic [spp_pkg::DATA_W-1:0] rdata;
		logic                       irq;
		logic                       end_of_buffer_flag;
		logic                       buffer_start_flag;
	} spp_state_s;

	spp_state_s st_r;
	spp_state_s st_nxt;

	logic [spp_pkg::DATA_W-1:0] mem [0:(1<<spp_pkg::ADDR_W)-1];

	logic                       seq_rd;
	logic                       seq_wr;
	logic                       rnd_wr;
	logic                       any_load;
	logic                       count_req;
	logic                       stop_hit;
	logic                       hit_status;
	logic                       hit_mask;
	logic                       hit_start1;
	logic                       hit_start2;
	logic                       hit_cmd;
	logic                       hit_end;
	logic                       hit_raddr;
	logic [spp_pkg::ADDR_W-1:0] ptr_nxt;
	logic                       skip_nxt;
	logic                       eob_nxt;
	logic                       buffer_start_flag_nxt;
	logic [spp_pkg::DATA_W-1:0] rd_word;
	logic [spp_pkg::EVT_W-1:0]  evt;
	logic [spp_pkg::EVT_W-1:0]  clr;
	logic                       release_req;

	// Widens an address into a register read word.
	function automatic logic [spp_pkg::DATA_W-1:0] spp_addr_word(
		input logic [spp_pkg::ADDR_W-1:0] a
	);
		spp_addr_word = {{(spp_pkg::DATA_W-spp_pkg::ADDR_W){1'b0}}, a};
	endfunction : spp_addr_word

	// Matches a register port access against one offset.
	function automatic logic spp_hit(
		input logic                       strobe,
		input logic [spp_pkg::REG_AW-1:0] addr,
		input logic [spp_pkg::REG_AW-1:0] ofs
	);
		spp_hit = strobe && (addr == ofs);
	endfunction : spp_hit

	//--------------------------------------------------------------------------
	// Access decode
	//--------------------------------------------------------------------------
	// Select high blocks both kinds of access on the sequential side.
	always_comb begin
		seq_rd     = !seq_select_n_i && seq_read_write_i;
		seq_wr     = !seq_select_n_i && !seq_read_write_i;
		rnd_wr     = spp_hit(reg_we_i, reg_addr_i, spp_pkg::OFS_RDATA);
		any_load   = !pointer_load_n_i || !buffer_one_start_load_n_i ||
		             !buffer_two_start_load_n_i;
		// A count request is ignored while halted or on the edge after a pin load.
		count_req  = !count_enable_n_i && !st_r.skip && !st_r.halted;
		// Reaching the end address with stop enabled halts instead of counting.
		stop_hit   = !count_enable_n_i && st_r.stop_en && !st_r.halted &&
		             (st_r.ptr == st_r.end_addr) && !any_load;
		hit_status = spp_hit(reg_we_i, reg_addr_i, spp_pkg::OFS_STATUS);
		hit_mask   = spp_hit(reg_we_i, reg_addr_i, spp_pkg::OFS_MASK);
		hit_start1 = spp_hit(reg_we_i, reg_addr_i, spp_pkg::OFS_START1);
		hit_start2 = spp_hit(reg_we_i, reg_addr_i, spp_pkg::OFS_START2);
		hit_cmd    = spp_hit(reg_we_i, reg_addr_i, spp_pkg::OFS_CMD);
		hit_end    = spp_hit(reg_we_i, reg_addr_i, spp_pkg::OFS_END);
		hit_raddr  = spp_hit(reg_we_i, reg_addr_i, spp_pkg::OFS_RADDR);
	end

	//--------------------------------------------------------------------------
	// Pointer
	//--------------------------------------------------------------------------
	// Pin load first, then buffer one, then buffer two, then counting.
	always_comb begin
		ptr_nxt  = st_r.ptr;
		skip_nxt = 1'b0;
		if (!pointer_load_n_i) begin
			ptr_nxt  = seq_addr_i;
			skip_nxt = 1'b1;
		end else if (!buffer_one_start_load_n_i) begin
			ptr_nxt = st_r.start1;
		end else if (!buffer_two_start_load_n_i) begin
			ptr_nxt = st_r.start2;
		end else if (count_req && !stop_hit) begin
			ptr_nxt = st_r.ptr + 1'b1;
		end
		// A high count enable falls through and keeps the pointer.
	end

	//--------------------------------------------------------------------------
	// Buffer flags
	//--------------------------------------------------------------------------
	// Flags follow the pointer value that the coming edge will hold.
	always_comb begin
		eob_nxt  = (ptr_nxt == st_r.end_addr);
		buffer_start_flag_nxt = (ptr_nxt == st_r.start1) || (ptr_nxt == st_r.start2);
	end

	//--------------------------------------------------------------------------
	// Register read mux
	//--------------------------------------------------------------------------
	// Unmapped offsets read as zero.
	always_comb begin
		rd_word = '0;
		case (reg_addr_i)
			spp_pkg::OFS_STATUS: begin
				rd_word[spp_pkg::EVT_W-1:0] = st_r.status;
			end
			spp_pkg::OFS_MASK: begin
				rd_word[spp_pkg::EVT_W-1:0] = st_r.mask;
			end
			spp_pkg::OFS_START1: begin
				rd_word = spp_addr_word(st_r.start1);
			end
			spp_pkg::OFS_START2: begin
				rd_word = spp_addr_word(st_r.start2);
			end
			spp_pkg::OFS_CMD: begin
				rd_word[spp_pkg::CMD_STOP_EN] = st_r.stop_en;
				rd_word[spp_pkg::CMD_HALT]    = st_r.halted;
			end
			spp_pkg::OFS_END: begin
				rd_word = spp_addr_word(st_r.end_addr);
			end
			spp_pkg::OFS_RADDR: begin
				rd_word = spp_addr_word(st_r.raddr);
			end
			spp_pkg::OFS_RDATA: begin
				rd_word = mem[st_r.raddr];
			end
			spp_pkg::OFS_PTR: begin
				rd_word = spp_addr_word(st_r.ptr);
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	//--------------------------------------------------------------------------
	// Next state
	//--------------------------------------------------------------------------
	always_comb begin
		st_nxt      = st_r;
		evt         = '0;
		clr         = '0;
		release_req = 1'b0;

		// Read/write state follows the line on every selected edge.
		if (!seq_select_n_i) begin
			st_nxt.rd_state = seq_read_write_i;
		end

		// Read data is registered from the pointer on a selected read edge.
		if (seq_rd) begin
			st_nxt.dout = mem[st_r.ptr];
		end
		st_nxt.doe = st_nxt.rd_state && !seq_output_enable_n_i;

		// The pointer section already holds the pointer on a stop hit.
		st_nxt.ptr  = ptr_nxt;
		st_nxt.skip = skip_nxt;
		if (stop_hit) begin
			st_nxt.halted = 1'b1;
		end

		// Flags reflect the pointer after this edge.
		st_nxt.end_of_buffer_flag  = eob_nxt;
		st_nxt.buffer_start_flag = buffer_start_flag_nxt;
		evt[spp_pkg::EVT_EOB]   = st_nxt.end_of_buffer_flag && !st_r.end_of_buffer_flag;
		evt[spp_pkg::EVT_START] = st_nxt.buffer_start_flag && !st_r.buffer_start_flag;

		// Software writes.
		if (hit_status) begin
			clr = reg_wdata_i[spp_pkg::EVT_W-1:0];
		end
		if (hit_mask) begin
			st_nxt.mask = reg_wdata_i[spp_pkg::EVT_W-1:0];
		end
		if (hit_start1) begin
			st_nxt.start1 = reg_wdata_i[spp_pkg::ADDR_W-1:0];
		end
		if (hit_start2) begin
			st_nxt.start2 = reg_wdata_i[spp_pkg::ADDR_W-1:0];
		end
		if (hit_end) begin
			st_nxt.end_addr = reg_wdata_i[spp_pkg::ADDR_W-1:0];
		end
		if (hit_raddr) begin
			st_nxt.raddr = reg_wdata_i[spp_pkg::ADDR_W-1:0];
		end
		if (hit_cmd) begin
			st_nxt.stop_en = reg_wdata_i[spp_pkg::CMD_STOP_EN];
			release_req    = !reg_wdata_i[spp_pkg::CMD_HALT];
		end
		// A halt caused in this same cycle wins over the release.
		if (release_req && st_r.halted) begin
			st_nxt.halted              = 1'b0;
			evt[spp_pkg::EVT_RESTART]  = 1'b1;
		end

		// Sticky events: a new event wins over a clear in the same cycle.
		st_nxt.status = (st_r.status & ~clr) | evt;
		st_nxt.irq    = |(st_nxt.status & st_nxt.mask);

		// Register reads answer in the next cycle; otherwise the read word is zero.
		st_nxt.rdata = reg_re_i ? rd_word : '0;
	end

	//--------------------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------------------
	// Reset forces the write state, so the data pins stay off until a read is clocked in.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			st_r          <= '0;
			st_r.rd_state <= 1'b0;
			st_r.doe      <= 1'b0;
			st_r.start1   <= spp_pkg::RST_START1;
			st_r.start2   <= spp_pkg::RST_START2;
			st_r.end_addr <= spp_pkg::RST_END;
			st_r.mask     <= spp_pkg::RST_MASK;
		end else begin
			st_r <= st_nxt;
		end
	end

	//--------------------------------------------------------------------------
	// Buffer memory
	//--------------------------------------------------------------------------
	// Contents are kept through reset; only the state registers in st_r are reset, to zero or to their reset values.
	// The random port write comes last, so it wins on a clash of addresses.
	always_ff @(posedge sys_clk_i) begin
		if (seq_wr && !rst_i) begin
			mem[st_r.ptr] <= seq_data_i;
		end
		if (rnd_wr && !rst_i) begin
			mem[st_r.raddr] <= reg_wdata_i;
		end
	end

	//--------------------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------------------
	// Every output is a register bit, so no pin sees a decode glitch.
	assign seq_data_o           = st_r.dout;
	assign seq_data_oe_o        = st_r.doe;
	assign end_of_buffer_flag_o = st_r.end_of_buffer_flag;
	assign buffer_start_flag_o  = st_r.buffer_start_flag;
	assign reg_rdata_o          = st_r.rdata;
	assign irq_o                = st_r.irq;

endmodule : spp_seq_port

// ---- spp_seq_port_assertions.sv ----
`timescale 1ns/100ps
module spp_seq_port_checker (
	// Clock and reset
	input wire logic                       sys_clk_i,
	input wire logic                       rst_i,
	// Sequential port controls
	input wire logic                       pointer_load_n_i,
	input wire logic                       count_enable_n_i,
	input wire logic                       buffer_one_start_load_n_i,
	input wire logic                       buffer_two_start_load_n_i,
	input wire logic                       seq_select_n_i,
	input wire logic                       seq_read_write_i,
	input wire logic                       seq_output_enable_n_i,
	input wire logic [spp_pkg::ADDR_W-1:0] seq_addr_i,
	// Software write strobe
	input wire logic                       reg_we_i,
	// Observed outputs
	input wire logic [spp_pkg::DATA_W-1:0] seq_data_o,
	input wire logic                       seq_data_oe_o,
	input wire logic                       end_of_buffer_flag_o,
	input wire logic                       buffer_start_flag_o
);
	// No pointer load and no software write that could change the memory.
	wire logic quiet = pointer_load_n_i & buffer_one_start_load_n_i & buffer_two_start_load_n_i
		& !reg_we_i;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence rd_s;
		!seq_select_n_i && seq_read_write_i && quiet;
	endsequence
	sequence cnt_rd_s;
		rd_s ##0 !count_enable_n_i;
	endsequence
	sequence hold_rd_s;
		rd_s ##0 count_enable_n_i;
	endsequence
	wr_off_a:
	assert property (!seq_select_n_i && !seq_read_write_i |=> !seq_data_oe_o)
		else $error("data driven after a write cycle");
	rd_on_a:
	assert property (rd_s ##0 !seq_output_enable_n_i |=> seq_data_oe_o)
		else $error("data not driven after a read cycle");
	rst_off_a:
	assert property (disable iff (1'h0) rst_i |=> !seq_data_oe_o)
		else $error("data driven after reset");
	idle_hold_a:
	assert property (seq_select_n_i |=> $stable(seq_data_o))
		else $error("read data changed without select");
	ptr_hold_a:
	assert property (hold_rd_s ##1 rd_s |=> $stable(seq_data_o))
		else $error("pointer moved with count disabled");
	load_skip_a:
	assert property (!pointer_load_n_i ##1 cnt_rd_s ##1 rd_s |=> $stable(seq_data_o))
		else $error("pointer moved right after a pin load");
	eob_load_a:
	assert property (!pointer_load_n_i && seq_addr_i == spp_pkg::RST_END |-> ##[1:2]
		end_of_buffer_flag_o)
		else $error("end flag missing after loading the end address");
	buffer_start_flag_load_a:
	assert property (pointer_load_n_i && !buffer_one_start_load_n_i |-> ##[1:2] buffer_start_flag_o)
		else $error("start flag missing after a buffer start load");
endmodule : spp_seq_port_checker

bind spp_seq_port spp_seq_port_checker spp_seq_port_checker_inst (.sys_clk_i, .rst_i,
	.pointer_load_n_i, .count_enable_n_i, .buffer_one_start_load_n_i, .buffer_two_start_load_n_i,
	.seq_select_n_i, .seq_read_write_i, .seq_output_enable_n_i, .reg_we_i, .seq_addr_i,
	.seq_data_o, .seq_data_oe_o, .end_of_buffer_flag_o, .buffer_start_flag_o);

// ---- spp_seq_master.sv ----
`timescale 1ns/100ps
module spp_seq_master (
	// Clock
	input  wire logic                  sys_clk_i,
	// Load, count, start one, start two, select, read/write, output enable
	output logic [6:0]                 ctl_o,
	output logic [spp_pkg::ADDR_W-1:0] addr_o,
	output logic [spp_pkg::DATA_W-1:0] data_o
);
	initial begin
		ctl_o = 7'h7F;
		addr_o = 13'h0000;
		data_o = 16'h0000;
	end
	// A released data bus shows the inverse of its last value, never a stale word.
	task automatic drive(input logic [6:0] c, input logic [12:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		ctl_o <= c;
		addr_o <= a;
		data_o <= (c[2] | c[1]) ? ~data_o : d;
	endtask : drive
endmodule : spp_seq_master

// ---- test_spp_seq_port.sv ----
`timescale 1ns/100ps
module test_spp_seq_port;
	logic        sys_clk_i, rst_i, reg_we_i, reg_re_i, seq_data_oe_o, irq_o;
	logic        end_of_buffer_flag_o, buffer_start_flag_o, pointer_load_n_i, count_enable_n_i;
	logic        buffer_one_start_load_n_i, buffer_two_start_load_n_i, seq_select_n_i;
	logic        seq_read_write_i, seq_output_enable_n_i;
	logic [6:0]  ctl;
	logic [12:0] seq_addr_i;
	logic [15:0] seq_data_i, seq_data_o, reg_wdata_i, reg_rdata_o, got;
	logic [3:0]  reg_addr_i;
	int          err_total = 0;
	int          tests_run = 0;
	assign {pointer_load_n_i, count_enable_n_i, buffer_one_start_load_n_i,
		buffer_two_start_load_n_i, seq_select_n_i, seq_read_write_i, seq_output_enable_n_i} = ctl;
	spp_seq_port spp_seq_port_inst (.sys_clk_i, .rst_i, .pointer_load_n_i, .count_enable_n_i,
		.buffer_one_start_load_n_i, .buffer_two_start_load_n_i, .seq_select_n_i, .seq_read_write_i,
		.seq_output_enable_n_i, .seq_addr_i, .seq_data_i, .seq_data_o, .seq_data_oe_o,
		.end_of_buffer_flag_o, .buffer_start_flag_o, .reg_addr_i, .reg_wdata_i, .reg_we_i,
		.reg_re_i, .reg_rdata_o, .irq_o);
	spp_seq_master spp_seq_master_inst (.sys_clk_i, .ctl_o(ctl), .addr_o(seq_addr_i),
		.data_o(seq_data_i));
	initial begin
		sys_clk_i = 1'h0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic st(input logic [6:0] c, input logic [12:0] a = 13'h0000,
		input logic [15:0] d = 16'h0000);
		spp_seq_master_inst.drive(c, a, d);
		#1;
	endtask : st
	task automatic rg(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		{reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} <= {w, !w, a, d};
		@(posedge sys_clk_i);
		{reg_we_i, reg_re_i} <= 2'h0;
		#1;
		got = reg_rdata_o;
	endtask : rg
	task automatic mem(input logic [12:0] a, input logic [15:0] e);
		rg(1'h1, spp_pkg::OFS_RADDR, {3'h0, a});
		rg(1'h0, spp_pkg::OFS_RDATA, 16'h0000);
		chk("mem", e, got);
	endtask : mem
	task automatic t_write;
		st(7'h3F, 13'h0100);
		st(7'h5F);
		for (int i = 0; i < 3; i++) begin
			st(7'h58, 13'h0000, 16'hA000 + 16'(i));
			chk("oe", 16'h0000, {15'h0000, seq_data_oe_o});
		end
		st(7'h78, 13'h0000, 16'hA003);
		st(7'h78, 13'h0000, 16'hA004);
		st(7'h7F);
		for (int i = 0; i < 3; i++) mem(13'h0100 + 13'(i), 16'hA000 + 16'(i));
		mem(13'h0103, 16'hA004);
	endtask : t_write
	task automatic t_read;
		st(7'h3F, 13'h0100);
		st(7'h5A);
		st(7'h5A);
		chk("dout", 16'hA000, seq_data_o);
		chk("oe", 16'h0001, {15'h0000, seq_data_oe_o});
		st(7'h7A);
		chk("dout", 16'hA000, seq_data_o);
		st(7'h7A);
		chk("dout", 16'hA001, seq_data_o);
		st(7'h58, 13'h0000, 16'hB00C);
		chk("dout", 16'hA001, seq_data_o);
		st(7'h7F);
		chk("oe", 16'h0000, {15'h0000, seq_data_oe_o});
		mem(13'h0101, 16'hB00C);
	endtask : t_read
	task automatic t_start;
		st(7'h6F);
		st(7'h5F);
		chk("buffer_start_flag", 16'h0001, {15'h0000, buffer_start_flag_o});
		st(7'h7F);
		rg(1'h0, spp_pkg::OFS_PTR, 16'h0000);
		chk("ptr", 16'h0001, got);
		st(7'h77);
		repeat (2) st(7'h5F);
		st(7'h7F);
		rg(1'h0, spp_pkg::OFS_PTR, 16'h0000);
		chk("ptr", 16'h1002, got);
	endtask : t_start
	task automatic t_restart;
		rg(1'h1, spp_pkg::OFS_CMD, 16'h0001);
		rg(1'h1, spp_pkg::OFS_MASK, 16'h0004);
		st(7'h3F, 13'h1FFF);
		st(7'h5F);
		chk("eob", 16'h0001, {15'h0000, end_of_buffer_flag_o});
		repeat (2) st(7'h5F);
		st(7'h7F);
		rg(1'h0, spp_pkg::OFS_CMD, 16'h0000);
		chk("cmd", 16'h0011, got);
		chk("irq", 16'h0000, {15'h0000, irq_o});
		rg(1'h1, spp_pkg::OFS_CMD, 16'h0000);
		for (int n = 0; n < 4 && irq_o !== 1'h1; n++) @(posedge sys_clk_i);
		chk("irq", 16'h0001, {15'h0000, irq_o});
		if (irq_o !== 1'h1)
			summarize();
		rg(1'h1, spp_pkg::OFS_STATUS, 16'h0004);
		@(posedge sys_clk_i);
		#1;
		chk("irq", 16'h0000, {15'h0000, irq_o});
		rg(1'h0, spp_pkg::OFS_STATUS, 16'h0000);
		chk("status", 16'h0003, got);
		st(7'h5F);
		st(7'h7F);
		rg(1'h0, spp_pkg::OFS_PTR, 16'h0000);
		chk("ptr", 16'h0000, got);
		rg(1'h0, 4'hF, 16'h0000);
		chk("unmapped", 16'h0000, got);
	endtask : t_restart
	task automatic summarize;
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		rst_i = 1'h1;
		{reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i} = 22'h000000;
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		t_write;
		t_read;
		t_start;
		t_restart;
		summarize();
	end
endmodule : test_spp_seq_port
